// file: verilog/e1ri_latches.sv
// Purpose: Latched E1 receive interrupt words with clear on read
// Assumes: Framer status, events and counters arrive on mclk
// Notes:   Only the analog loss flag comes from a pin
// Operation
// - Word zero bit 7 sets on any frame sync change.
// - Word zero bit 6 sets on any multiframe sync change.
// - Word zero bit 5 sets on any CRC-4 sync change.
// - Word zero bit 4 sets when all-ones condition starts or ends.
// - Word zero bit 3 sets while analog loss or 192 zeros persist.
// - Word zero bit 2 sets when two last FAS were errored.
// - Word zero bit 1 sets on any Y-bit status change.
// - Word zero bit 0 sets on receive controlled frame slip.
// - Masked sources never set their status bit.
// - Reading a word clears its latched bits.
// - Word one bit 7 sets on FAS bit error while in frame sync.
// - Word one bit 6 sets on local CRC-4 failure.
// - Word one bit 5 sets on received E-bit error.
// - Word one bit 4 sets when slot 16 is all ones.
// - Word one bit 3 sets on non-HDB3 bipolar violation.
// - Word one bit 2 sets on PRBS checker error.
// - Word one bit 1 sets on 512 alternating bits.
// - Word one bit 0 sets when remote alarm bit is one.
// - Word two bits 7,6,5,3,2 set on counter wrap FFH to 00H.
// - Word two bit 1 sets on PRBS multiframe counter wrap.
`timescale 1ns/1ps
`include "e1ri_map.svh"

module e1ri_latches (
  input  wire logic                  mclk,
  input  wire logic                  arst_n,
  input  wire logic                  ce,
  input  wire logic                  rd_en,
  input  wire logic [3:0]            rd_page,
  input  wire logic [4:0]            rd_addr,
  output logic [7:0]                 rd_data,
  output logic                       rd_valid,
  input  wire e1ri_pkg::e1ri_status_t rx_status,
  input  wire e1ri_pkg::e1ri_event_t rx_event,
  input  wire e1ri_pkg::e1ri_count_t rx_count,
  input  wire logic                  rx_bit,
  input  wire logic                  rx_bit_en,
  input  wire logic                  analog_los,
  input  wire logic [7:0]            unmask_sync,
  input  wire logic [7:0]            unmask_line,
  input  wire logic [7:0]            unmask_wrap,
  output logic                       irq_n
);
  import e1ri_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic is_wrap(input logic [7:0] prev,
                                   input logic [7:0] cur);
    is_wrap = (prev == `E1RI_CNT_TOP) && (cur == `E1RI_CNT_ZERO);
  endfunction : is_wrap

  function automatic logic word_hit(input logic [3:0] page,
                                    input logic [4:0] addr,
                                    input logic [4:0] ofs);
    word_hit = (page == `E1RI_PAGE) && (addr == ofs);
  endfunction : word_hit

  ////////////////////////////////////////////////////////////////////
  // Reset and pin synchronisers

  logic rst_meta_r;
  logic rst_n_r;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  logic los_meta_r;
  logic los_sync_r;
  logic los_meta_nxt;
  logic los_sync_nxt;

  always_comb begin
    los_meta_nxt = analog_los;
    los_sync_nxt = los_meta_r;
  end

  always_ff @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      los_meta_r <= 1'b0;
      los_sync_r <= 1'b0;
    end else if (ce) begin
      los_meta_r <= los_meta_nxt;
      los_sync_r <= los_sync_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Received bit runs

  logic prev_bit_r;
  logic prev_bit_nxt;
  logic zero_run;
  logic alt_run;

  always_comb begin
    prev_bit_nxt = rx_bit_en ? rx_bit : prev_bit_r;
  end

  e1ri_run u_zero_run (
    .mclk   (mclk),
    .rst_n  (rst_n_r),
    .ce     (ce),
    .bit_en (rx_bit_en),
    .match  (!rx_bit),
    .target (`E1RI_LOS_ZEROS),
    .full   (zero_run)
  );

  // Alternation run
  // Counts transitions, so one fewer than the bit total
  e1ri_run u_alt_run (
    .mclk   (mclk),
    .rst_n  (rst_n_r),
    .ce     (ce),
    .bit_en (rx_bit_en),
    .match  (rx_bit != prev_bit_r),
    .target (`E1RI_AUXP_BITS - 10'd1),
    .full   (alt_run)
  );

  ////////////////////////////////////////////////////////////////////
  // Previous samples for change detection

  e1ri_status_t stat_prev_r;
  e1ri_status_t stat_prev_nxt;
  e1ri_count_t  cnt_prev_r;
  e1ri_count_t  cnt_prev_nxt;
  logic         alt_prev_r;
  logic         alt_prev_nxt;
  logic         primed_r;
  logic         primed_nxt;

  always_comb begin
    stat_prev_nxt = rx_status;
    cnt_prev_nxt  = rx_count;
    alt_prev_nxt  = alt_run;
    primed_nxt    = 1'b1;
  end

  // First cycle only loads history; avoids false changes after reset
  always_ff @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      stat_prev_r <= '0;
      cnt_prev_r  <= '0;
      alt_prev_r  <= 1'b0;
      primed_r    <= 1'b0;
      prev_bit_r  <= 1'b0;
    end else if (ce) begin
      stat_prev_r <= stat_prev_nxt;
      cnt_prev_r  <= cnt_prev_nxt;
      alt_prev_r  <= alt_prev_nxt;
      primed_r    <= primed_nxt;
      prev_bit_r  <= prev_bit_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Raw sources per word

  e1ri_words_t raw;
  e1ri_words_t unmask;
  e1ri_words_t used;
  e1ri_words_t set;
  e1ri_words_t clr;
  e1ri_words_t word_r;
  e1ri_words_t word_nxt;
  logic        loss;

  always_comb begin
    loss = los_sync_r | zero_run;
    raw  = '0;
    raw[0][7] = rx_status.frame_sync ^ stat_prev_r.frame_sync;
    raw[0][6] = rx_status.mf_sync ^ stat_prev_r.mf_sync;
    raw[0][5] = rx_status.crc_sync ^ stat_prev_r.crc_sync;
    raw[0][4] = rx_status.all_ones ^ stat_prev_r.all_ones;
    raw[0][3] = loss;
    raw[0][2] = rx_event.cons_fas_err;
    raw[0][1] = rx_status.y_bit ^ stat_prev_r.y_bit;
    raw[0][0] = rx_event.slip;
    raw[1][7] = rx_event.fas_bit_err & rx_status.frame_sync;
    raw[1][6] = rx_event.crc_err;
    raw[1][5] = rx_event.ebit_err;
    raw[1][4] = rx_event.ts16_ones;
    raw[1][3] = rx_event.bpv;
    raw[1][2] = rx_event.prbs_err;
    raw[1][1] = alt_run & ~alt_prev_r;
    raw[1][0] = rx_event.rai_bit;
    raw[2][7] = is_wrap(cnt_prev_r.fas, rx_count.fas);
    raw[2][6] = is_wrap(cnt_prev_r.crc, rx_count.crc);
    raw[2][5] = is_wrap(cnt_prev_r.ebit, rx_count.ebit);
    raw[2][3] = is_wrap(cnt_prev_r.bpv, rx_count.bpv);
    raw[2][2] = is_wrap(cnt_prev_r.prbs, rx_count.prbs);
    raw[2][1] = is_wrap(cnt_prev_r.prbs_mf, rx_count.prbs_mf);
    // Change edges are void until history is valid
    if (!primed_r) begin
      raw[0] = raw[0] & {1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
      raw[1] = raw[1] & 8'hFD;
      raw[2] = 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Word latches

  assign unmask = {unmask_wrap, unmask_line, unmask_sync};
  assign used   = {`E1RI_USED_WRAP, `E1RI_USED_LINE, `E1RI_USED_SYNC};

  localparam logic [2:0][4:0] WORD_OFS =
    {`E1RI_OFS_WRAP, `E1RI_OFS_LINE, `E1RI_OFS_SYNC};

  genvar gw;
  generate
    for (gw = 0; gw < 3; gw++) begin : g_word
      assign set[gw] = raw[gw] & unmask[gw] & used[gw];
      assign clr[gw] = {8{rd_en && word_hit(rd_page, rd_addr, WORD_OFS[gw])}};
      // Set beats clear so a same-cycle event survives the read
      assign word_nxt[gw] = (word_r[gw] & ~clr[gw]) | set[gw];
    end
  endgenerate

  always_ff @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      word_r <= {3{`E1RI_WORD_RST}};
    end else if (ce) begin
      word_r <= word_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read port

  logic [7:0] rd_data_r;
  logic [7:0] rd_data_nxt;
  logic       rd_valid_r;
  logic       rd_valid_nxt;

  // Reports the value held before the clear takes effect
  always_comb begin
    rd_data_nxt  = rd_data_r;
    rd_valid_nxt = rd_en;
    if (rd_en) begin
      if (word_hit(rd_page, rd_addr, `E1RI_OFS_SYNC)) begin
        rd_data_nxt = word_r[0];
      end else if (word_hit(rd_page, rd_addr, `E1RI_OFS_LINE)) begin
        rd_data_nxt = word_r[1];
      end else if (word_hit(rd_page, rd_addr, `E1RI_OFS_WRAP)) begin
        rd_data_nxt = word_r[2];
      end else begin
        rd_data_nxt = 8'h00;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rd_data_r  <= 8'h00;
      rd_valid_r <= 1'b0;
    end else if (ce) begin
      rd_data_r  <= rd_data_nxt;
      rd_valid_r <= rd_valid_nxt;
    end
  end

  assign rd_data  = rd_data_r;
  assign rd_valid = rd_valid_r;

  ////////////////////////////////////////////////////////////////////
  // Interrupt request

  assign irq_n = ~(|(word_r[0] & used[0]) |
                   |(word_r[1] & used[1]) |
                   |(word_r[2] & used[2]));

endmodule : e1ri_latches

// file: verilog/e1ri_map.svh
// Purpose: Constants for the E1 receive interrupt latches
// Assumes: Included by the latch block only
// Notes:   Offsets are within register page 4
`ifndef E1RI_MAP_SVH
`define E1RI_MAP_SVH

`define E1RI_PAGE        4'h4
`define E1RI_OFS_SYNC    5'h1B
`define E1RI_OFS_LINE    5'h1C
`define E1RI_OFS_WRAP    5'h1D

`define E1RI_WORD_RST    8'h00
`define E1RI_USED_SYNC   8'hFF
`define E1RI_USED_LINE   8'hFF
`define E1RI_USED_WRAP   8'hEE

`define E1RI_CNT_TOP     8'hFF
`define E1RI_CNT_ZERO    8'h00

`define E1RI_LOS_ZEROS   10'd192
`define E1RI_AUXP_BITS   10'd512

`endif

// file: verilog/e1ri_pkg.sv
// Purpose: Types for the E1 receive interrupt latches
// Assumes: Framer sources share mclk
// Notes:   Constants live in e1ri_map.svh
package e1ri_pkg;

  typedef struct packed {
    logic frame_sync;
    logic mf_sync;
    logic crc_sync;
    logic all_ones;
    logic y_bit;
  } e1ri_status_t;

  typedef struct packed {
    logic cons_fas_err;
    logic slip;
    logic fas_bit_err;
    logic crc_err;
    logic ebit_err;
    logic ts16_ones;
    logic bpv;
    logic prbs_err;
    logic rai_bit;
  } e1ri_event_t;

  typedef struct packed {
    logic [7:0] fas;
    logic [7:0] crc;
    logic [7:0] ebit;
    logic [7:0] bpv;
    logic [7:0] prbs;
    logic [7:0] prbs_mf;
  } e1ri_count_t;

  typedef logic [2:0][7:0] e1ri_words_t;

endpackage : e1ri_pkg

// file: verilog/e1ri_run.sv
// Purpose: Counts consecutive qualifying received bits
// Assumes: bit_en marks one received bit per pulse
// Notes:   Saturates, so full stays high for the whole run
`timescale 1ns/1ps

module e1ri_run (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  input  wire logic       bit_en,
  input  wire logic       match,
  input  wire logic [9:0] target,
  output logic            full
);

  logic [9:0] cnt_r;
  logic [9:0] cnt_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (bit_en) begin
      if (!match) begin
        cnt_nxt = 10'h000;
      end else if (cnt_r != target) begin
        cnt_nxt = cnt_r + 10'h001;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 10'h000;
    end else if (ce) begin
      cnt_r <= cnt_nxt;
    end
  end

  assign full = (cnt_r == target);

endmodule : e1ri_run

// file: test/e1ri_latches_props.sv
// Purpose: Port assertions for the interrupt latches
// Assumes: Single mclk domain
// Notes:   ok skips history priming after reset
`timescale 1ns/1ps

module e1ri_props (
  input wire logic                   mclk,
  input wire logic                   arst_n,
  input wire logic                   ce,
  input wire logic                   rd_en,
  input wire logic [3:0]             rd_page,
  input wire logic [4:0]             rd_addr,
  input wire logic [7:0]             rd_data,
  input wire logic                   rd_valid,
  input wire e1ri_pkg::e1ri_status_t rx_status,
  input wire e1ri_pkg::e1ri_event_t  rx_event,
  input wire e1ri_pkg::e1ri_count_t  rx_count,
  input wire logic                   analog_los,
  input wire logic [7:0]             unmask_sync,
  input wire logic [7:0]             unmask_line,
  input wire logic [7:0]             unmask_wrap,
  input wire logic                   irq_n
);
  import e1ri_pkg::*;
  logic [2:0] ok_r;
  logic [2:0] ok_nxt;
  logic       ok;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  always_comb ok_nxt = (ce && !ok_r[2]) ? ok_r + 3'h1 : ok_r;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) ok_r <= 3'h0;
    else ok_r <= ok_nxt;
  end
  assign ok = ok_r[2];
  ////////////////////////////////////////////////////////////
  property p_take; ce |=> rd_valid == $past(rd_en); endproperty
  a_take: assert property (p_take) else $error("read answer wrong");
  property p_hold; !rd_valid |-> $stable(rd_data); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_unused;
    rd_valid && $past(rd_addr) == 5'h1D |-> rd_data[4] == 1'b0 && rd_data[0] == 1'b0;
  endproperty
  a_unused: assert property (p_unused) else $error("unused bit set");
  property p_sync;
    ok && ce && $past(ce) && unmask_sync[7] && $changed(rx_status.frame_sync) |=> !irq_n;
  endproperty
  a_sync: assert property (p_sync) else $error("sync change lost");
  property p_slip; ok && ce && rx_event.slip && unmask_sync[0] |=> !irq_n; endproperty
  a_slip: assert property (p_slip) else $error("slip lost");
  property p_crc; ok && ce && rx_event.crc_err && unmask_line[6] |=> !irq_n; endproperty
  a_crc: assert property (p_crc) else $error("crc error lost");
  property p_wrap;
    ok && ce && $past(ce) && $past(rx_count.fas) == 8'hFF && rx_count.fas == 8'h00
      && unmask_wrap[7] |=> !irq_n;
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap lost");
  property p_los; (ok && ce && analog_los && unmask_sync[3])[*3] |=> !irq_n; endproperty
  a_los: assert property (p_los) else $error("loss lost");
  property p_mask;
    ok && irq_n && unmask_sync == 8'h00 && unmask_line == 8'h00 && unmask_wrap == 8'h00
      |=> irq_n;
  endproperty
  a_mask: assert property (p_mask) else $error("masked source set");
  c_w0: cover property (rd_valid && $past(rd_addr) == 5'h1B && rd_data != 8'h00);
  c_w2: cover property (rd_valid && $past(rd_addr) == 5'h1D && rd_data != 8'h00);
  c_irq: cover property ($fell(irq_n));
endmodule : e1ri_props

bind e1ri_latches e1ri_props i_e1ri_props (
  .mclk        (mclk),
  .arst_n      (arst_n),
  .ce          (ce),
  .rd_en       (rd_en),
  .rd_page     (rd_page),
  .rd_addr     (rd_addr),
  .rd_data     (rd_data),
  .rd_valid    (rd_valid),
  .rx_status   (rx_status),
  .rx_event    (rx_event),
  .rx_count    (rx_count),
  .analog_los  (analog_los),
  .unmask_sync (unmask_sync),
  .unmask_line (unmask_line),
  .unmask_wrap (unmask_wrap),
  .irq_n       (irq_n)
);

// file: test/tb_e1ri_latches.sv
// Purpose: Random and directed checks of the latches
// Assumes: Inputs change on falling mclk
// Notes:   Sources pulse one cycle, then words are read
`timescale 1ns/1ps

module tb_e1ri_latches;
  import e1ri_pkg::*;
  logic         mclk, arst_n, ce, rd_en, rd_valid, irq_n;
  logic         rx_bit, rx_bit_en, analog_los;
  logic [3:0]   rd_page;
  logic [4:0]   rd_addr;
  logic [7:0]   rd_data, unmask_sync, unmask_line, unmask_wrap;
  e1ri_status_t rx_status;
  e1ri_event_t  rx_event;
  e1ri_count_t  rx_count;
  int           miscompares = 0;
  int           total_checks = 0;
  int           cyc = 0;

  e1ri_latches i_e1ri_latches (
    .mclk        (mclk),
    .arst_n      (arst_n),
    .ce          (ce),
    .rd_en       (rd_en),
    .rd_page     (rd_page),
    .rd_addr     (rd_addr),
    .rd_data     (rd_data),
    .rd_valid    (rd_valid),
    .rx_status   (rx_status),
    .rx_event    (rx_event),
    .rx_count    (rx_count),
    .rx_bit      (rx_bit),
    .rx_bit_en   (rx_bit_en),
    .analog_los  (analog_los),
    .unmask_sync (unmask_sync),
    .unmask_line (unmask_line),
    .unmask_wrap (unmask_wrap),
    .irq_n       (irq_n)
  );

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      results;
    end
  end
  ////////////////////////////////////////////////////////////
  function automatic logic [7:0] x0(input logic [4:0] c, input logic [8:0] v);
    return {c[4:1], 1'b0, v[8], c[0], v[7]};
  endfunction : x0
  function automatic logic [7:0] x1(input logic [8:0] v, input logic f);
    return {v[6] & f, v[5:1], 1'b0, v[0]};
  endfunction : x1
  function automatic logic [47:0] cnt(input logic [5:0] w, input logic a);
    logic [47:0] r;
    for (int i = 0; i < 6; i++) r[8*i+:8] = w[i] ? (a ? 8'hFF : 8'h00) : (a ? 8'h10 : 8'h11);
    return r;
  endfunction : cnt
  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    rd_en = 1'b1;
    rd_addr = a;
    @(negedge mclk);
    chk(8'h01, {7'h00, rd_valid});
    chk(e, rd_data);
  endtask : rd
  task automatic trial(input logic [7:0] m0, m1, m2, input logic [4:0] c,
                       input logic [8:0] v, input logic [5:0] w);
    logic [7:0] e0, e1, e2;
    unmask_sync = m0;
    unmask_line = m1;
    unmask_wrap = m2;
    rx_count = cnt(w, 1'b1);
    @(negedge mclk);
    rx_count = cnt(w, 1'b0);
    rx_status = rx_status ^ c;
    rx_event = v;
    @(negedge mclk);
    rx_event = '0;
    e0 = x0(c, v) & m0;
    e1 = x1(v, rx_status.frame_sync) & m1;
    e2 = {w[5:3], 1'b0, w[2:0], 1'b0} & m2;
    chk({7'h00, ~|{e0, e1, e2}}, {7'h00, irq_n});
    rd(5'h1B, e0);
    rd(5'h1C, e1);
    rd(5'h1D, e2);
    rd_en = 1'b0;
    @(negedge mclk);
    chk(8'h01, {7'h00, irq_n});
  endtask : trial
  task automatic results;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results
  ////////////////////////////////////////////////////////////
  initial begin
    {arst_n, rd_en, rx_bit, rx_bit_en, analog_los, rd_addr} = '0;
    {unmask_sync, unmask_line, unmask_wrap, rx_status, rx_event, rx_count} = '0;
    ce = 1'b1;
    rd_page = 4'h3;
    void'($urandom(32'h82A2));
    repeat (10) @(negedge mclk);
    arst_n = 1'b1;
    repeat (4) @(negedge mclk);
    rd(5'h1B, 8'h00);
    rd_page = 4'h4;
    rd(5'h1E, 8'h00);
    rd_en = 1'b0;
    trial(8'hFF, 8'hFF, 8'hFF, 5'h1F, 9'h1FF, 6'h3F);
    trial(8'h00, 8'h00, 8'h00, 5'h1F, 9'h1FF, 6'h3F);
    repeat (40) trial(8'($urandom()), 8'($urandom()), 8'($urandom()),
                      5'($urandom()), 9'($urandom()), 6'($urandom()));
    unmask_sync = 8'h08;
    analog_los = 1'b1;
    repeat (4) @(negedge mclk);
    rd(5'h1B, 8'h08);
    rd(5'h1B, 8'h08);
    rd_en = 1'b0;
    analog_los = 1'b0;
    repeat (4) @(negedge mclk);
    rd(5'h1B, 8'h08);
    rd(5'h1B, 8'h00);
    rx_bit_en = 1'b1;
    rd_en = 1'b0;
    repeat (191) @(negedge mclk);
    rx_bit_en = 1'b0;
    rd(5'h1B, 8'h00);
    rd(5'h1B, 8'h00);
    rd_en = 1'b0;
    rx_bit_en = 1'b1;
    repeat (2) @(negedge mclk);
    rx_bit_en = 1'b0;
    repeat (2) @(negedge mclk);
    rd(5'h1B, 8'h08);
    rd_en = 1'b0;
    unmask_sync = 8'h00;
    unmask_line = 8'h02;
    rx_bit_en = 1'b1;
    for (int i = 0; i < 512; i++) begin
      rx_bit = i[0];
      @(negedge mclk);
      if (i == 510) begin
        rx_bit_en = 1'b0;
        repeat (2) @(negedge mclk);
        rd(5'h1C, 8'h00);
        rd_en = 1'b0;
        rx_bit_en = 1'b1;
      end
    end
    rx_bit_en = 1'b0;
    repeat (2) @(negedge mclk);
    rd(5'h1C, 8'h02);
    rd(5'h1C, 8'h00);
    rd(5'h1B, 8'h08);
    rd_en = 1'b0;
    unmask_line = 8'h40;
    @(negedge mclk);
    // Enable low must freeze latches and read port
    ce = 1'b0;
    rx_event.crc_err = 1'b1;
    rd_en = 1'b1;
    @(negedge mclk);
    chk(8'h01, {7'h00, irq_n});
    chk(8'h00, {7'h00, rd_valid});
    ce = 1'b1;
    // Event in the read cycle survives the clear
    rd(5'h1C, 8'h00);
    rx_event = '0;
    rd(5'h1C, 8'h40);
    rd_en = 1'b0;
    @(negedge mclk);
    chk(8'h01, {7'h00, irq_n});
    results;
  end
endmodule : tb_e1ri_latches
